// File: src/hdi_mover.sv
// one-doubleword mover between system memory and local embedded memory
`timescale 1ns/10ps
module hdi_mover (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // control from the channel registers
  input wire logic go_i,
  input wire logic dir_i,
  input wire logic [31:0] sys_addr_i,
  input wire logic [15:0] loc_addr_i,
  output logic busy_o,
  output logic word_done_o,
  // system memory master
  output hdi_pkg::hdi_sys_req_s sys_o,
  input wire logic sys_gnt_i,
  input wire logic sys_rvalid_i,
  input wire logic [31:0] sys_rdata_i,
  // local embedded memory
  output hdi_pkg::hdi_loc_req_s loc_o,
  input wire logic [31:0] loc_rdata_i
);
  import hdi_pkg::*;

  hdi_mover_state_e state_ff;
  hdi_mover_state_e nxt_state;
  logic [31:0] data_ff;
  logic [31:0] nxt_data;

  // RULE_10: direction picks path
  always_comb begin
    nxt_state = state_ff;
    nxt_data = data_ff;
    word_done_o = 1'b0;
    unique case (state_ff)
      MV_IDLE: begin
        if (go_i) begin
          nxt_state = dir_i ? MV_SYS_RD : MV_LOC_RD;
        end
      end
      MV_LOC_RD: nxt_state = MV_LOC_CAP;
      MV_LOC_CAP: begin
        nxt_data = loc_rdata_i;
        nxt_state = MV_SYS_WR;
      end
      MV_SYS_WR: begin
        if (sys_gnt_i) begin
          word_done_o = 1'b1;
          nxt_state = MV_IDLE;
        end
      end
      MV_SYS_RD: begin
        if (sys_gnt_i) begin
          nxt_state = MV_SYS_WAIT;
        end
      end
      MV_SYS_WAIT: begin
        if (sys_rvalid_i) begin
          nxt_data = sys_rdata_i;
          nxt_state = MV_LOC_WR;
        end
      end
      MV_LOC_WR: begin
        word_done_o = 1'b1;
        nxt_state = MV_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_ff <= MV_IDLE;
      data_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      data_ff <= nxt_data;
    end
  end

  always_comb begin
    busy_o = (state_ff != MV_IDLE);
    sys_o.req = (state_ff == MV_SYS_WR) || (state_ff == MV_SYS_RD);
    sys_o.we = (state_ff == MV_SYS_WR);
    sys_o.addr = sys_addr_i;
    sys_o.wdata = data_ff;
    loc_o.req = (state_ff == MV_LOC_RD) || (state_ff == MV_LOC_WR);
    loc_o.we = (state_ff == MV_LOC_WR);
    loc_o.addr = loc_addr_i;
    loc_o.wdata = data_ff;
  end

  sequence s_loc_read;
    loc_o.req && !loc_o.we;
  endsequence

  sequence s_sys_write_follows;
    ##2 (sys_o.req && sys_o.we && sys_o.wdata == $past(loc_rdata_i));
  endsequence

  chk_loc_to_sys: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_07
    s_loc_read |-> s_sys_write_follows)
    else $error("local read not followed by system write of that data");

  chk_sys_to_loc: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_07
    (sys_rvalid_i && state_ff == MV_SYS_WAIT) |=> (loc_o.req && loc_o.we && loc_o.wdata == $past(sys_rdata_i)))
    else $error("system read data not written to local memory");
endmodule

// File: src/hdi_params.svh
// register offsets, field positions, reset values and steps of the host dma and interrupt status block
`ifndef HDI_PARAMS_SVH
`define HDI_PARAMS_SVH

`define HDI_ADDR_W 12
`define HDI_OFS_GSTAT 12'h0f0
`define HDI_OFS_GMASK 12'h0f1
`define HDI_OFS_PTR 12'h220
`define HDI_OFS_CNT 12'h224
`define HDI_OFS_CTRL 12'h228
`define HDI_OFS_FLAG 12'h2f0
`define HDI_OFS_CMASK 12'h2f1

`define HDI_GBIT_DISP0 7
`define HDI_GBIT_DISP1 6
`define HDI_GBIT_CAPT 5
`define HDI_GBIT_VGA 4
`define HDI_GBIT_DMA 2
`define HDI_GMASK_IMPL 8'hf4

`define HDI_CTRL_EN 0
`define HDI_CTRL_DIR 2
`define HDI_FLAG_DONE 2
`define HDI_CMASK_DONE 2

`define HDI_GMASK_RST 8'h00
`define HDI_PTR_RST 32'h0000_0000
`define HDI_CNT_RST 24'h00_0000
`define HDI_CNT_W 24
`define HDI_PTR_STEP 32'h0000_0004
`define HDI_CNT_STEP 24'h00_0004

`endif

// File: src/hdi_pkg.sv
// types shared by the host dma and interrupt status block
package hdi_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } hdi_reg_req_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } hdi_sys_req_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [31:0] wdata;
  } hdi_loc_req_s;

  typedef struct packed {
    logic disp0;
    logic disp1;
    logic capt;
    logic vga;
  } hdi_unit_irq_s;

  typedef enum logic [2:0] {
    MV_IDLE,
    MV_LOC_RD,
    MV_LOC_CAP,
    MV_SYS_WR,
    MV_SYS_RD,
    MV_SYS_WAIT,
    MV_LOC_WR
  } hdi_mover_state_e;
endpackage

// File: src/hdi_sync2.sv
// two flip-flop synchroniser for level inputs from other clock domains
`timescale 1ns/10ps
module hdi_sync2 #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // level in and synchronised level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb begin
    nxt_meta = d_i;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign q_o = sync_ff;
endmodule

// File: src/hdi_top.sv
// host dma channel with global interrupt status and mask
// What this block does
// RULE_01: each global status bit reads as the or of its unit's pending flags and the status byte is read-only.
// RULE_02: clearing a global mask bit only stops reporting and leaves pending flags and status untouched.
// RULE_03: the interrupt output works without the bus clock so external events can wake a sleeping system.
// RULE_04: status and mask bits are display 0 at 7, display 1 at 6, capture at 5, vga at 4, dma at 2, rest reserved.
// RULE_05: a status bit reads 1 when its event occurred, and a mask bit of 1 enables reporting.
// RULE_06: the global mask resets to zero so every source starts disabled.
// RULE_07: the channel moves doublewords between circular queues in system memory and local embedded memory.
// RULE_08: software loads the system memory pointer with a doubleword-aligned address.
// RULE_09: software loads the 24-bit count as byte count minus four in whole doublewords.
// RULE_10: control bit 2 picks direction, 0 local to system and 1 system to local.
// RULE_11: control bit 0 enables the channel, resets to 0, and hardware never clears it.
// RULE_12: the driver disables the channel before reprogramming it and enables it afterwards.
// RULE_13: completion sets flag bit 2, which feeds the global dma status bit and clears on a written one.
// RULE_14: channel mask bit 2 gates the completion interrupt, 1 enables it.
// RULE_15: while enabled the pointer steps by four per doubleword and the flag rises when the count runs out.
// RULE_16: the interrupt output is high while any status bit is set with its global mask bit set.
`timescale 1ns/10ps
`include "hdi_params.svh"
module hdi_top #(
  parameter int LOC_AW = 10
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // register port
  input hdi_pkg::hdi_reg_req_s reg_i,
  output logic [31:0] reg_rdata_o,
  // pending flags from the other units
  input hdi_pkg::hdi_unit_irq_s unit_irq_i,
  // system memory master
  output hdi_pkg::hdi_sys_req_s sys_o,
  input wire logic sys_gnt_i,
  input wire logic sys_rvalid_i,
  input wire logic [31:0] sys_rdata_i,
  // local embedded memory
  output hdi_pkg::hdi_loc_req_s loc_o,
  input wire logic [31:0] loc_rdata_i,
  // interrupt to host
  output logic irq_o
);
  import hdi_pkg::*;

  if (LOC_AW < 1 || LOC_AW > 16) begin : g_bad_aw
    $error("LOC_AW must lie between 1 and 16");
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [7:0] gmask_ff;
  logic [7:0] nxt_gmask;
  logic [31:0] ptr_ff;
  logic [31:0] nxt_ptr;
  logic [23:0] cnt_ff;
  logic [23:0] nxt_cnt;
  logic en_ff;
  logic nxt_en;
  logic dir_ff;
  logic nxt_dir;
  logic done_ff;
  logic nxt_done;
  logic flag_ff;
  logic nxt_flag;
  logic cmask_ff;
  logic nxt_cmask;
  logic [LOC_AW-1:0] loc_idx_ff;
  logic [LOC_AW-1:0] nxt_loc_idx;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  logic [3:0] unit_raw;
  logic [3:0] unit_sync;
  logic [7:0] stat_vec;
  logic [7:0] stat_raw;
  logic dma_pend;
  logic go;
  logic busy;
  logic word_done;
  logic last_word;
  logic [15:0] loc_addr;

  assign unit_raw = {unit_irq_i.disp0, unit_irq_i.disp1, unit_irq_i.capt, unit_irq_i.vga};

  hdi_sync2 #(
    .W(4)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .d_i(unit_raw),
    .q_o(unit_sync)
  );

  // RULE_14: channel mask gates pending
  assign dma_pend = flag_ff & cmask_ff;

  // RULE_04: status bit placement
  always_comb begin
    stat_vec = 8'h00;
    stat_raw = 8'h00;
    // RULE_01: unit flags ored in
    stat_vec[`HDI_GBIT_DISP0] = unit_sync[3];
    stat_vec[`HDI_GBIT_DISP1] = unit_sync[2];
    stat_vec[`HDI_GBIT_CAPT] = unit_sync[1];
    stat_vec[`HDI_GBIT_VGA] = unit_sync[0];
    // RULE_13: flag feeds global bit
    stat_vec[`HDI_GBIT_DMA] = dma_pend;
    stat_raw[`HDI_GBIT_DISP0] = unit_raw[3];
    stat_raw[`HDI_GBIT_DISP1] = unit_raw[2];
    stat_raw[`HDI_GBIT_CAPT] = unit_raw[1];
    stat_raw[`HDI_GBIT_VGA] = unit_raw[0];
    stat_raw[`HDI_GBIT_DMA] = dma_pend;
  end

  // RULE_03: clockless interrupt path
  // RULE_16: any unmasked status bit
  assign irq_o = |(stat_raw & gmask_ff);

  // RULE_09: zero count means last word
  assign last_word = (cnt_ff == `HDI_CNT_RST);
  assign go = en_ff & ~done_ff;
  assign loc_addr = 16'(loc_idx_ff);

  hdi_mover u_mover (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .go_i(go),
    .dir_i(dir_ff),
    .sys_addr_i(ptr_ff),
    .loc_addr_i(loc_addr),
    .busy_o(busy),
    .word_done_o(word_done),
    .sys_o(sys_o),
    .sys_gnt_i(sys_gnt_i),
    .sys_rvalid_i(sys_rvalid_i),
    .sys_rdata_i(sys_rdata_i),
    .loc_o(loc_o),
    .loc_rdata_i(loc_rdata_i)
  );

  always_comb begin
    nxt_gmask = gmask_ff;
    nxt_ptr = ptr_ff;
    nxt_cnt = cnt_ff;
    nxt_en = en_ff;
    nxt_dir = dir_ff;
    nxt_done = done_ff;
    nxt_flag = flag_ff;
    nxt_cmask = cmask_ff;
    nxt_loc_idx = loc_idx_ff;
    // RULE_02: mask write touches mask only
    if (reg_i.wr && hit(reg_i.addr, `HDI_OFS_GMASK)) begin
      nxt_gmask = reg_i.wdata[7:0] & `HDI_GMASK_IMPL;
    end
    if (reg_i.wr && hit(reg_i.addr, `HDI_OFS_CMASK)) begin
      nxt_cmask = reg_i.wdata[`HDI_CMASK_DONE];
    end
    // RULE_11: only software changes enable
    if (reg_i.wr && hit(reg_i.addr, `HDI_OFS_CTRL)) begin
      nxt_en = reg_i.wdata[`HDI_CTRL_EN];
      nxt_dir = reg_i.wdata[`HDI_CTRL_DIR];
    end
    // RULE_15: pointer and count step per word
    if (reg_i.wr && hit(reg_i.addr, `HDI_OFS_PTR)) begin
      nxt_ptr = reg_i.wdata;
    end else if (word_done) begin
      nxt_ptr = ptr_ff + `HDI_PTR_STEP;
    end
    if (reg_i.wr && hit(reg_i.addr, `HDI_OFS_CNT)) begin
      nxt_cnt = reg_i.wdata[`HDI_CNT_W-1:0];
    end else if (word_done && !last_word) begin
      nxt_cnt = cnt_ff - `HDI_CNT_STEP;
    end
    // RULE_07: local index wraps round the queue
    if (!en_ff && !busy) begin
      nxt_loc_idx = '0;
    end else if (word_done) begin
      nxt_loc_idx = loc_idx_ff + 1'b1;
    end
    if (!en_ff) begin
      nxt_done = 1'b0;
    end else if (word_done && last_word) begin
      nxt_done = 1'b1;
    end
    // RULE_13: set wins over write-one clear
    if (word_done && last_word) begin
      nxt_flag = 1'b1;
    end else if (reg_i.wr && hit(reg_i.addr, `HDI_OFS_FLAG) && reg_i.wdata[`HDI_FLAG_DONE]) begin
      nxt_flag = 1'b0;
    end
  end

  // RULE_05: read mux
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_i.rd) begin
      if (hit(reg_i.addr, `HDI_OFS_GSTAT)) begin
        nxt_rdata[7:0] = stat_vec;
      end else if (hit(reg_i.addr, `HDI_OFS_GMASK)) begin
        nxt_rdata[7:0] = gmask_ff;
      end else if (hit(reg_i.addr, `HDI_OFS_PTR)) begin
        nxt_rdata = ptr_ff;
      end else if (hit(reg_i.addr, `HDI_OFS_CNT)) begin
        nxt_rdata[`HDI_CNT_W-1:0] = cnt_ff;
      end else if (hit(reg_i.addr, `HDI_OFS_CTRL)) begin
        nxt_rdata[`HDI_CTRL_EN] = en_ff;
        nxt_rdata[`HDI_CTRL_DIR] = dir_ff;
      end else if (hit(reg_i.addr, `HDI_OFS_FLAG)) begin
        nxt_rdata[`HDI_FLAG_DONE] = flag_ff;
      end else if (hit(reg_i.addr, `HDI_OFS_CMASK)) begin
        nxt_rdata[`HDI_CMASK_DONE] = cmask_ff;
      end
    end
  end

  // RULE_06: mask resets to zero
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      gmask_ff <= `HDI_GMASK_RST;
      ptr_ff <= `HDI_PTR_RST;
      cnt_ff <= `HDI_CNT_RST;
      en_ff <= 1'b0;
      dir_ff <= 1'b0;
      done_ff <= 1'b0;
      flag_ff <= 1'b0;
      cmask_ff <= 1'b0;
      loc_idx_ff <= '0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      gmask_ff <= nxt_gmask;
      ptr_ff <= nxt_ptr;
      cnt_ff <= nxt_cnt;
      en_ff <= nxt_en;
      dir_ff <= nxt_dir;
      done_ff <= nxt_done;
      flag_ff <= nxt_flag;
      cmask_ff <= nxt_cmask;
      loc_idx_ff <= nxt_loc_idx;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;

  logic ctrl_wr;
  assign ctrl_wr = reg_i.wr && hit(reg_i.addr, `HDI_OFS_CTRL);

  chk_status_read: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_01
    (reg_i.rd && reg_i.addr == `HDI_OFS_GSTAT) |=> (reg_rdata_o == {24'h00_0000, $past(stat_vec)}))
    else $error("status read does not show ored unit flags");

  chk_mask_keeps_flag: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_02
    (reg_i.wr && reg_i.addr == `HDI_OFS_GMASK && !word_done) |=> $stable(flag_ff))
    else $error("mask write changed a pending flag");

  chk_irq_masked: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_16
    (gmask_ff == 8'h00) |-> !irq_o)
    else $error("interrupt raised with all sources masked");

  chk_mask_reset: assert property (@(posedge core_clk_i) // RULE_06
    reset_i |=> (gmask_ff == 8'h00 && !irq_o))
    else $error("mask not zero after reset");

  chk_dir_select: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_10
    (sys_o.req && !sys_o.we) |-> dir_ff)
    else $error("system read issued in local to system direction");

  chk_enable_sticky: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_11
    (en_ff && !ctrl_wr) |=> en_ff)
    else $error("enable cleared without a software write");

  chk_flag_set: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_13
    (word_done && last_word) |=> (flag_ff && done_ff == $past(en_ff)))
    else $error("completion flag not set after last word");

  chk_flag_clear: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_13
    (reg_i.wr && reg_i.addr == `HDI_OFS_FLAG && reg_i.wdata[2] && !word_done) |=> !flag_ff)
    else $error("writing one did not clear completion flag");

  chk_ptr_advance: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_15
    (word_done && !(reg_i.wr && reg_i.addr == `HDI_OFS_PTR)) |=> (ptr_ff == $past(ptr_ff) + 32'h0000_0004))
    else $error("pointer did not step by four bytes");

  chk_chan_mask: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_14
    !cmask_ff |-> !stat_vec[2])
    else $error("masked completion reported in global status");

  sequence s_final_word;
    word_done && last_word;
  endsequence

  sequence s_mover_rests;
    !busy [*2];
  endsequence

  chk_rest_after_done: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_15
    s_final_word |=> s_mover_rests)
    else $error("channel started another word after the final one");

  chk_cnt_step: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_15
    (word_done && !last_word && !(reg_i.wr && reg_i.addr == `HDI_OFS_CNT))
      |=> (cnt_ff == $past(cnt_ff) - 24'h00_0004))
    else $error("count did not step down by four");

  chk_dma_irq: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_16
    (flag_ff && cmask_ff && gmask_ff[`HDI_GBIT_DMA]) |-> irq_o)
    else $error("unmasked completion did not raise the interrupt");

  chk_rdata_idle: assert property (@(posedge core_clk_i) disable iff (reset_i) // RULE_05
    !reg_i.rd |=> (reg_rdata_o == 32'h0000_0000))
    else $error("read data shown outside the read answer cycle");
endmodule

// File: tb/hdi_sysmem_model.sv
// system memory partner answering the dma master with a programmable latency
`timescale 1ns/10ps
module hdi_sysmem_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // master request and latency choice
  input hdi_pkg::hdi_sys_req_s sys_i,
  input wire logic [2:0] lat_i,
  // answer
  output logic gnt_o,
  output logic rvalid_o,
  output logic [31:0] rdata_o
);
  import hdi_pkg::*;
  logic [31:0] mem [0:255];
  logic [2:0] wait_ff;
  logic [3:0] rcnt_ff;
  logic rpend_ff;
  logic [7:0] ridx_ff;
  logic [31:0] last_ff;
  assign gnt_o = sys_i.req && (wait_ff == lat_i);
  assign rvalid_o = rpend_ff && (rcnt_ff == 4'h0);
  // released data bus shows the inverse of the last word
  assign rdata_o = rvalid_o ? mem[ridx_ff] : ~last_ff;
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      wait_ff <= 3'h0;
      rpend_ff <= 1'b0;
      rcnt_ff <= 4'h0;
      last_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= (sys_i.req && !gnt_o) ? wait_ff + 3'h1 : 3'h0;
      if (gnt_o && sys_i.we) begin
        mem[sys_i.addr[9:2]] <= sys_i.wdata;
      end
      if (gnt_o && !sys_i.we) begin
        rpend_ff <= 1'b1;
        rcnt_ff <= {1'b0, lat_i};
        ridx_ff <= sys_i.addr[9:2];
      end else if (rvalid_o) begin
        rpend_ff <= 1'b0;
        last_ff <= rdata_o;
      end else if (rpend_ff) begin
        rcnt_ff <= rcnt_ff - 4'h1;
      end
    end
  end
endmodule

// File: tb/hdi_top_tb.sv
// self-checking bench for the host dma channel and interrupt status
`timescale 1ns/10ps
`include "hdi_params.svh"
module hdi_top_tb;
  import hdi_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_run = 1'b1;
  hdi_reg_req_s reg_q = '0;
  logic [31:0] reg_rdata;
  hdi_unit_irq_s unit_irq = '0;
  hdi_sys_req_s sys_req;
  logic sys_gnt, sys_rvalid;
  logic [31:0] sys_rdata;
  hdi_loc_req_s loc_req;
  logic [31:0] loc_rdata;
  logic irq;
  logic [2:0] lat = 3'h0;
  logic [31:0] loc_mem [0:15];
  logic loc_rd_ff = 1'b0;
  logic [3:0] loc_a_ff = 4'h0;
  logic [31:0] v, ptr, w [0:7];
  logic [3:0] u;
  logic [7:0] m;
  logic dir;
  int seed = 95;
  int errors = 0;
  int n_compared = 0;
  int r, i, k, n;

  always #5 if (clk_run) core_clk_i = ~core_clk_i;

  hdi_top #(.LOC_AW(10)) u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_i(reg_q),
    .reg_rdata_o(reg_rdata), .unit_irq_i(unit_irq), .sys_o(sys_req), .sys_gnt_i(sys_gnt),
    .sys_rvalid_i(sys_rvalid), .sys_rdata_i(sys_rdata), .loc_o(loc_req), .loc_rdata_i(loc_rdata),
    .irq_o(irq));
  hdi_sysmem_model u_mem (.core_clk_i(core_clk_i), .reset_i(reset_i), .sys_i(sys_req), .lat_i(lat),
    .gnt_o(sys_gnt), .rvalid_o(sys_rvalid), .rdata_o(sys_rdata));

  // local memory answers in the cycle after a read request
  always @(posedge core_clk_i) begin
    if (loc_req.req && loc_req.we) begin
      loc_mem[loc_req.addr[3:0]] <= loc_req.wdata;
    end
    loc_rd_ff <= loc_req.req && !loc_req.we;
    loc_a_ff <= loc_req.addr[3:0];
  end
  assign loc_rdata = loc_rd_ff ? loc_mem[loc_a_ff] : ~loc_mem[loc_a_ff];

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    reg_q <= '0;
  endtask

  task reg_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge core_clk_i);
    reg_q <= '0;
    #1;
    d = reg_rdata;
  endtask

  function automatic logic [31:0] exp_stat(input logic [3:0] uf, input logic d);
    return {24'h00_0000, uf, 1'b0, d, 2'b00};
  endfunction

  task print_verdict;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #300000;
    errors = errors + 1;
    print_verdict;
  end

  initial begin
    for (i = 0; i < 16; i++) loc_mem[i] = 32'h0000_0000;
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    reg_rd(`HDI_OFS_GMASK, v); chk(v, 32'h0000_0000);
    reg_rd(`HDI_OFS_CTRL, v); chk(v, 32'h0000_0000);
    reg_rd(`HDI_OFS_GSTAT, v); chk(v, 32'h0000_0000);
    reg_rd(12'h3fc, v); chk(v, 32'h0000_0000);
    chk(irq, 1'b0);
    for (k = 0; k < 8; k++) begin
      u = (k == 0) ? 4'hf : 4'($random(seed));
      m = (k == 0) ? 8'hff : 8'($random(seed));
      @(posedge core_clk_i);
      unit_irq <= hdi_unit_irq_s'(u);
      reg_wr(`HDI_OFS_GMASK, {24'h0, m});
      reg_rd(`HDI_OFS_GMASK, v); chk(v, {24'h0, m & `HDI_GMASK_IMPL});
      reg_rd(`HDI_OFS_GSTAT, v); chk(v, exp_stat(u, 1'b0));
      chk(irq, |({u, 4'h0} & m));
      reg_wr(`HDI_OFS_GSTAT, 32'h0000_00ff);
      reg_wr(`HDI_OFS_GMASK, 32'h0000_0000);
      reg_rd(`HDI_OFS_GSTAT, v); chk(v, exp_stat(u, 1'b0));
      chk(irq, 1'b0);
    end
    reg_wr(`HDI_OFS_GMASK, 32'h0000_00f4);
    @(posedge core_clk_i);
    unit_irq <= '0;
    @(negedge core_clk_i);
    clk_run = 1'b0;
    #20 unit_irq <= '{disp0: 1'b0, disp1: 1'b1, capt: 1'b0, vga: 1'b0};
    #20 chk(irq, 1'b1);
    unit_irq <= '0;
    #20 chk(irq, 1'b0);
    clk_run = 1'b1;
    for (r = 0; r < 4; r++) begin
      dir = r[0];
      n = (r == 0) ? 1 : 2 + ($random(seed) & 3);
      ptr = 32'h0000_0040 * (r + 1);
      lat <= 3'($random(seed));
      for (i = 0; i < n; i++) begin
        w[i] = $random(seed);
        if (dir) u_mem.mem[ptr[9:2] + i] = w[i];
        else loc_mem[i] = w[i];
      end
      reg_wr(`HDI_OFS_PTR, ptr);
      reg_wr(`HDI_OFS_CNT, 4 * (n - 1));
      reg_wr(`HDI_OFS_CMASK, 32'h0000_0004);
      reg_wr(`HDI_OFS_CTRL, {29'h0, dir, 2'b01});
      for (k = 0; k < 400 && irq !== 1'b1; k++) @(posedge core_clk_i);
      #1 chk(irq, 1'b1);
      for (i = 0; i < n; i++) chk(dir ? loc_mem[i] : u_mem.mem[ptr[9:2] + i], w[i]);
      reg_rd(`HDI_OFS_PTR, v); chk(v, ptr + 4 * n);
      reg_rd(`HDI_OFS_CNT, v); chk(v, 32'h0000_0000);
      reg_rd(`HDI_OFS_CTRL, v); chk(v, {29'h0, dir, 2'b01});
      reg_rd(`HDI_OFS_GSTAT, v); chk(v, exp_stat(4'h0, 1'b1));
      reg_wr(`HDI_OFS_GMASK, 32'h0000_0000);
      reg_rd(`HDI_OFS_GSTAT, v); chk(v, exp_stat(4'h0, 1'b1));
      chk(irq, 1'b0);
      reg_rd(`HDI_OFS_FLAG, v); chk(v, 32'h0000_0004);
      reg_wr(`HDI_OFS_GMASK, 32'h0000_00f4);
      reg_wr(`HDI_OFS_CMASK, 32'h0000_0000);
      reg_rd(`HDI_OFS_GSTAT, v); chk(v, exp_stat(4'h0, 1'b0));
      chk(irq, 1'b0);
      reg_wr(`HDI_OFS_FLAG, 32'h0000_00fb);
      reg_rd(`HDI_OFS_FLAG, v); chk(v, 32'h0000_0004);
      reg_wr(`HDI_OFS_FLAG, 32'h0000_0004);
      reg_rd(`HDI_OFS_FLAG, v); chk(v, 32'h0000_0000);
      reg_wr(`HDI_OFS_CTRL, 32'h0000_0000);
    end
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    reg_rd(`HDI_OFS_GMASK, v); chk(v, 32'h0000_0000);
    print_verdict;
  end
endmodule
